// File: hw/pll_cfg_pkg.sv
// Constants, field layouts, reset images and carrier types for the loop configuration block.
// Assumes a byte-wide register port with a five-bit register address on the same clock.
package pll_cfg_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int SET_COUNT = 4;
  localparam int OUT_COUNT = 6;

  // ---------------------------------------------------------------
  // Register addresses (one byte each)
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_FB_BASE = 5'h00;
  localparam logic [4:0] ADDR_OUT_BASE = 5'h04;
  localparam logic [4:0] ADDR_CTRL_BASE = 5'h08;
  localparam logic [4:0] ADDR_STYLE_BASE = 5'h0C;
  localparam logic [4:0] ADDR_DRIVE_BASE = 5'h10;
  localparam logic [4:0] ADDR_LAST = 5'h17;

  // ---------------------------------------------------------------
  // Field positions in the control byte
  // ---------------------------------------------------------------
  localparam int CTRL_PUMP_LSB = 0;
  localparam int CTRL_INDIV_LSB = 2;
  localparam int CTRL_PRE_LSB = 4;
  localparam int CTRL_SKIP_BIT = 6;

  // Byte bit that carries each output's enable or style, index is the output number
  localparam logic [5:0][2:0] Q_BIT_POS = {3'h7, 3'h6, 3'h5, 3'h3, 3'h2, 3'h1};

  // ---------------------------------------------------------------
  // Decode tables
  // ---------------------------------------------------------------
  localparam logic [2:0] IN_DIV_RATIO_0 = 3'h1;
  localparam logic [2:0] IN_DIV_RATIO_1 = 3'h2;
  localparam logic [2:0] IN_DIV_RATIO_2 = 3'h4;
  localparam logic [2:0] IN_DIV_RATIO_3 = 3'h5;
  localparam logic [6:0] OUT_DIV_MIN = 7'h02;
  localparam logic [6:0] OUT_DIV_ODD_LIMIT = 7'h05;
  localparam logic [7:0] FB_CODE_MIN = 8'h08;
  localparam logic [7:0] FB_CODE_MAX = 8'h7D;
  localparam logic [8:0] PUMP0_MIN = 9'h010;
  localparam logic [8:0] PUMP0_MAX = 9'h030;
  localparam logic [8:0] PUMP1_MIN = 9'h030;
  localparam logic [8:0] PUMP1_MAX = 9'h064;
  localparam logic [8:0] PUMP2_MIN = 9'h064;
  localparam logic [8:0] PUMP2_MAX = 9'h0FA;
  localparam logic [8:0] PUMP3_MIN = 9'h0C0;
  localparam logic [8:0] PUMP3_MAX = 9'h0FA;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {PRE_HALF, PRE_ONE, PRE_TWO} prescale_t;

  typedef struct packed {
    logic [7:0] fb_div_code;
    logic [6:0] out_div_code;
    logic loop_skip;
    logic [1:0] prescale_sel;
    logic [1:0] input_div_sel;
    logic [1:0] pump_current_sel;
    logic [5:0] out_drive_on;
    logic [5:0] out_style_pick;
  } cfg_set_t;

  typedef struct packed {
    logic [2:0] input_div;
    prescale_t prescale;
    logic [8:0] fb_div;
    logic [6:0] out_div;
    logic [1:0] pump_current_sel;
    logic loop_skip;
    logic fb_range_ok;
    logic pump_range_ok;
    logic [10:0] freq_num;
    logic [10:0] freq_den;
  } loop_ctrl_t;

  // ---------------------------------------------------------------
  // Factory images, index is the set number
  // ---------------------------------------------------------------
  localparam cfg_set_t [3:0] CFG_RESET = {
    cfg_set_t'{8'h4B, 7'h06, 1'b0, 2'h0, 2'h1, 2'h2, 6'h3F, 6'h00},
    cfg_set_t'{8'h20, 7'h04, 1'b0, 2'h2, 2'h0, 2'h1, 6'h3F, 6'h3F},
    cfg_set_t'{8'h14, 7'h08, 1'b0, 2'h2, 2'h0, 2'h0, 6'h3F, 6'h3F},
    cfg_set_t'{8'h19, 7'h08, 1'b0, 2'h2, 2'h0, 2'h1, 6'h3F, 6'h3F}
  };

endpackage

// File: hw/sync3.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes rst_n is already synchronous to clock.
`timescale 1ns/1ps
module sync3 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pin side
  input wire logic [WIDTH-1:0] async_in,
  // Clock side
  output logic [WIDTH-1:0] stable_out
);

  logic [WIDTH-1:0] ff1_reg;
  logic [WIDTH-1:0] ff2_reg;
  logic [WIDTH-1:0] ff3_reg;
  logic [WIDTH-1:0] stable_reg;
  wire [WIDTH-1:0] differ = ff2_reg ^ ff3_reg;
  wire [WIDTH-1:0] stable_next = (ff2_reg & ~differ) | (stable_reg & differ);

  if (WIDTH < 1) begin : g_check
    $error("sync3 WIDTH must be at least 1");
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ff1_reg <= '0;
      ff2_reg <= '0;
      ff3_reg <= '0;
      stable_reg <= '0;
    end else begin
      ff1_reg <= async_in;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      stable_reg <= stable_next;
    end
  end

  assign stable_out = stable_reg;

endmodule

// File: hw/pll_config_field_decode.sv
// Four configuration sets for the synthesizer loop, their register port and field decode.
// Assumes the serial front end presents byte writes and reads on this clock;
// select pins arrive asynchronously.
`timescale 1ns/1ps

module pll_config_field_decode
  import pll_cfg_pkg::*;
#(
  parameter int SETS = SET_COUNT,
  parameter int OUTPUTS = OUT_COUNT
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  // Select pins
  input wire logic clk_src_sel_pin,
  input wire logic [1:0] freq_set_pick_pin,
  // Loop and output controls
  output logic [1:0] active_set,
  output loop_ctrl_t loop_ctrl,
  output logic [5:0] out_drive_on,
  output logic [5:0] out_style_pick
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (SETS != SET_COUNT || OUTPUTS != OUT_COUNT) begin : g_check
    $error("register map serves exactly four sets and six outputs");
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [5:0] extract_q(input logic [7:0] b);
    logic [5:0] q;
    q = '0;
    for (int i = 0; i < OUT_COUNT; i++) begin
      q[i] = b[Q_BIT_POS[i]];
    end
    return q;
  endfunction

  function automatic logic [7:0] insert_q(input logic [5:0] q);
    logic [7:0] b;
    b = '0;
    for (int i = 0; i < OUT_COUNT; i++) begin
      b[Q_BIT_POS[i]] = q[i];
    end
    return b;
  endfunction

  function automatic logic [2:0] decode_input_div(input logic [1:0] sel, input logic xtal);
    logic [2:0] r;
    r = IN_DIV_RATIO_0;
    if (!xtal) begin
      case (sel)
        2'h0: r = IN_DIV_RATIO_0;
        2'h1: r = IN_DIV_RATIO_1;
        2'h2: r = IN_DIV_RATIO_2;
        default: r = IN_DIV_RATIO_3;
      endcase
    end
    return r;
  endfunction

  function automatic prescale_t decode_prescale(input logic [1:0] sel);
    prescale_t p;
    p = PRE_TWO;
    if (sel == 2'h0) begin
      p = PRE_ONE;
    end else if (sel == 2'h1) begin
      p = PRE_HALF;
    end
    return p;
  endfunction

  function automatic logic [6:0] decode_out_div(input logic [6:0] code);
    logic [6:0] n;
    n = {code[6:1], 1'b0};
    if (code < OUT_DIV_MIN) begin
      n = OUT_DIV_MIN;
    end else if (code <= OUT_DIV_ODD_LIMIT) begin
      n = code;
    end
    return n;
  endfunction

  function automatic logic pump_range_check(input logic [1:0] sel, input logic [8:0] m);
    logic ok;
    ok = 1'b0;
    case (sel)
      2'h0: ok = (m >= PUMP0_MIN) && (m <= PUMP0_MAX);
      2'h1: ok = (m >= PUMP1_MIN) && (m <= PUMP1_MAX);
      2'h2: ok = (m >= PUMP2_MIN) && (m <= PUMP2_MAX);
      default: ok = (m >= PUMP3_MIN) && (m <= PUMP3_MAX);
    endcase
    return ok;
  endfunction

  // ---------------------------------------------------------------
  // Factory image checks
  // ---------------------------------------------------------------
  for (genvar s = 0; s < SET_COUNT; s++) begin : g_image
    if (CFG_RESET[s].fb_div_code < FB_CODE_MIN ||
        CFG_RESET[s].fb_div_code > FB_CODE_MAX) begin : g_bad_fb
      $error("factory feedback code outside the legal window");
    end
    if (!pump_range_check(CFG_RESET[s].pump_current_sel,
                          {CFG_RESET[s].fb_div_code, 1'b0})) begin : g_bad_pump
      $error("factory pump code outside its feedback window");
    end
  end

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  wire rst_n = rst_sync_reg[1];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // ---------------------------------------------------------------
  // Select pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pins_stable;
  wire clk_src_is_clk = pins_stable[2];
  wire [1:0] set_pick = pins_stable[1:0];

  sync3 #(
    .WIDTH(3)
  ) u_pin_sync (
    .clock(clock),
    .rst_n(rst_n),
    .async_in({clk_src_sel_pin, freq_set_pick_pin}),
    .stable_out(pins_stable)
  );

  // ---------------------------------------------------------------
  // Configuration bank
  // ---------------------------------------------------------------
  cfg_set_t bank_reg [SET_COUNT];
  cfg_set_t bank_next [SET_COUNT];

  for (genvar s = 0; s < SET_COUNT; s++) begin : g_set
    wire hit_fb = reg_wr_en && (reg_addr == ADDR_FB_BASE + 5'(s));
    wire hit_out = reg_wr_en && (reg_addr == ADDR_OUT_BASE + 5'(s));
    wire hit_ctrl = reg_wr_en && (reg_addr == ADDR_CTRL_BASE + 5'(s));
    wire hit_style = reg_wr_en && (reg_addr == ADDR_STYLE_BASE + 5'(s));
    wire hit_drive = reg_wr_en && (reg_addr == ADDR_DRIVE_BASE + 5'(s));

    // Independent fields per set
    assign bank_next[s].fb_div_code = hit_fb ? reg_wr_data : bank_reg[s].fb_div_code;
    assign bank_next[s].out_div_code = hit_out ? reg_wr_data[6:0] : bank_reg[s].out_div_code;
    assign bank_next[s].loop_skip = hit_ctrl ? reg_wr_data[CTRL_SKIP_BIT] :
                                    bank_reg[s].loop_skip;
    assign bank_next[s].prescale_sel = hit_ctrl ? reg_wr_data[CTRL_PRE_LSB +: 2] :
                                       bank_reg[s].prescale_sel;
    assign bank_next[s].input_div_sel = hit_ctrl ? reg_wr_data[CTRL_INDIV_LSB +: 2] :
                                        bank_reg[s].input_div_sel;
    assign bank_next[s].pump_current_sel = hit_ctrl ? reg_wr_data[CTRL_PUMP_LSB +: 2] :
                                           bank_reg[s].pump_current_sel;
    assign bank_next[s].out_style_pick = hit_style ? extract_q(reg_wr_data) :
                                         bank_reg[s].out_style_pick;
    assign bank_next[s].out_drive_on = hit_drive ? extract_q(reg_wr_data) :
                                       bank_reg[s].out_drive_on;

    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        bank_reg[s] <= CFG_RESET[s];
      end else begin
        bank_reg[s] <= bank_next[s];
      end
    end
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  wire [1:0] rd_set = reg_addr[1:0];
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (reg_addr > ADDR_LAST) begin
      rd_byte = 8'h00;
    end else if (reg_addr >= ADDR_DRIVE_BASE) begin
      rd_byte = insert_q(bank_reg[rd_set].out_drive_on);
      if (reg_addr > ADDR_DRIVE_BASE + 5'h03) begin
        rd_byte = 8'h00;
      end
    end else if (reg_addr >= ADDR_STYLE_BASE) begin
      rd_byte = insert_q(bank_reg[rd_set].out_style_pick);
    end else if (reg_addr >= ADDR_CTRL_BASE) begin
      rd_byte[CTRL_SKIP_BIT] = bank_reg[rd_set].loop_skip;
      rd_byte[CTRL_PRE_LSB +: 2] = bank_reg[rd_set].prescale_sel;
      rd_byte[CTRL_INDIV_LSB +: 2] = bank_reg[rd_set].input_div_sel;
      rd_byte[CTRL_PUMP_LSB +: 2] = bank_reg[rd_set].pump_current_sel;
    end else if (reg_addr >= ADDR_OUT_BASE) begin
      rd_byte = {1'b0, bank_reg[rd_set].out_div_code};
    end else begin
      rd_byte = bank_reg[rd_set].fb_div_code;
    end
  end

  logic [7:0] rd_data_reg;
  wire [7:0] rd_data_next = reg_rd_en ? rd_byte : rd_data_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // ---------------------------------------------------------------
  // Active set selection and decode
  // ---------------------------------------------------------------
  // Set chosen by the select pins
  wire cfg_set_t act = bank_reg[set_pick];
  wire [2:0] dec_input_div = decode_input_div(act.input_div_sel, !clk_src_is_clk);
  wire prescale_t dec_prescale = decode_prescale(act.prescale_sel);
  wire [8:0] dec_fb_div = {act.fb_div_code, 1'b0};
  wire [6:0] dec_out_div = decode_out_div(act.out_div_code);
  // Host-side legality, flagged only
  wire dec_fb_ok = (act.fb_div_code >= FB_CODE_MIN) && (act.fb_div_code <= FB_CODE_MAX);
  // Pump code against its feedback window
  wire dec_pump_ok = pump_range_check(act.pump_current_sel, dec_fb_div);

  // Ratio in half steps: num = M*2*PS (or 2*PS when bypassed), den = 2*P*N
  wire [1:0] pre_shift = (dec_prescale == PRE_TWO) ? 2'h2 :
                         (dec_prescale == PRE_ONE) ? 2'h1 : 2'h0;
  wire [10:0] loop_gain = act.loop_skip ? 11'h001 : {2'h0, dec_fb_div};
  wire [10:0] dec_num = loop_gain << pre_shift;
  wire [9:0] p_times_n = 10'(dec_input_div * dec_out_div);
  wire [10:0] dec_den = {p_times_n, 1'b0};

  loop_ctrl_t ctrl_next;
  assign ctrl_next.input_div = dec_input_div;
  assign ctrl_next.prescale = dec_prescale;
  assign ctrl_next.fb_div = dec_fb_div;
  assign ctrl_next.out_div = dec_out_div;
  assign ctrl_next.pump_current_sel = act.pump_current_sel;
  assign ctrl_next.loop_skip = act.loop_skip;
  assign ctrl_next.fb_range_ok = dec_fb_ok;
  assign ctrl_next.pump_range_ok = dec_pump_ok;
  assign ctrl_next.freq_num = dec_num;
  assign ctrl_next.freq_den = dec_den;

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  loop_ctrl_t ctrl_reg;
  logic [1:0] active_set_reg;
  logic [5:0] drive_reg;
  logic [5:0] style_reg;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= '0;
      active_set_reg <= 2'h0;
      drive_reg <= 6'h00;
      style_reg <= 6'h00;
    end else begin
      ctrl_reg <= ctrl_next;
      active_set_reg <= set_pick;
      drive_reg <= act.out_drive_on;
      style_reg <= act.out_style_pick;
    end
  end

  assign reg_rd_data = rd_data_reg;
  assign loop_ctrl = ctrl_reg;
  assign active_set = active_set_reg;
  assign out_drive_on = drive_reg;
  assign out_style_pick = style_reg;

endmodule

// File: tb/host_model.sv
// Host model that reaches the configuration bytes one strobe at a time.
// Assumes the block samples its strobes on the rising edge of clock.
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic clock,
  // Register port
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data
);
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr = 5'h00;
    reg_wr_data = 8'h00;
  end
  // ---------------------------------------------------------------
  // Byte transfers
  // ---------------------------------------------------------------
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clock);
    reg_wr_en <= 1'b0;
    reg_wr_data <= ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    @(negedge clock);
    d = reg_rd_data;
  endtask
  // ---------------------------------------------------------------
  // Legal field choices
  // ---------------------------------------------------------------
  function automatic logic [7:0] pick_fb();
    pick_fb = 8'h08 + 8'($urandom_range(117));
  endfunction
  function automatic logic [1:0] pick_pump(input logic [7:0] c);
    logic [8:0] m;
    m = {c, 1'b0};
    if (m <= 9'h030) pick_pump = (m == 9'h030) ? 2'h1 : 2'h0;
    else if (m < 9'h064) pick_pump = 2'h1;
    else pick_pump = (m >= 9'h0C0) ? 2'(2 + $urandom_range(1)) : 2'h2;
  endfunction
  function automatic logic [1:0] pick_pre();
    pick_pre = ($urandom_range(3) != 0) ? 2'h2 : 2'($urandom_range(1));
  endfunction
endmodule

// File: tb/pll_cfg_chk.sv
// Port checker for the loop configuration block.
// Assumes one clock domain and resetn low clearing the outputs.
`timescale 1ns/1ps
module pll_cfg_chk
  import pll_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  input wire logic [7:0] reg_rd_data,
  // Pins and controls
  input wire logic clk_src_sel_pin,
  input wire logic [1:0] freq_set_pick_pin,
  input wire logic [1:0] active_set,
  input wire loop_ctrl_t loop_ctrl,
  input wire logic [5:0] out_drive_on,
  input wire logic [5:0] out_style_pick
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire [8:0] fb = loop_ctrl.fb_div;
  wire [1:0] pc = loop_ctrl.pump_current_sel;
  wire [1:0] sh = (loop_ctrl.prescale == PRE_HALF) ? 2'h0 :
    (loop_ctrl.prescale == PRE_ONE) ? 2'h1 : 2'h2;
  wire pwin = (pc == 2'h0) ? (fb inside {[9'h010:9'h030]}) :
    (pc == 2'h1) ? (fb inside {[9'h030:9'h064]}) :
    (pc == 2'h2) ? (fb inside {[9'h064:9'h0FA]}) : (fb inside {[9'h0C0:9'h0FA]});
  fb_even_a: assert property (fb[0] == 1'b0) else $error("odd feedback divide");
  in_div_a: assert property (loop_ctrl.out_div != 7'h00 |->
    loop_ctrl.input_div inside {3'h1, 3'h2, 3'h4, 3'h5}) else $error("bad input divide");
  out_div_a: assert property (loop_ctrl.out_div != 7'h00 |-> loop_ctrl.out_div >= 7'h02 &&
    (loop_ctrl.out_div <= 7'h05 || !loop_ctrl.out_div[0])) else $error("bad output divide");
  crystal_one_a: assert property ((!clk_src_sel_pin)[*8] |->
    loop_ctrl.input_div == 3'h1) else $error("crystal divide not one");
  den_rel_a: assert property (loop_ctrl.freq_den ==
    11'(2 * loop_ctrl.input_div * loop_ctrl.out_div)) else $error("ratio denominator wrong");
  num_rel_a: assert property (loop_ctrl.freq_num ==
    (11'(loop_ctrl.loop_skip ? 9'h001 : fb) << sh)) else $error("ratio numerator wrong");
  pump_win_a: assert property (loop_ctrl.pump_range_ok == pwin) else $error("pump flag wrong");
  set_follow_a: assert property ($stable(freq_set_pick_pin)[*8] |->
    active_set == freq_set_pick_pin) else $error("active set not following pins");
  wr_apply_a: assert property (reg_wr_en && reg_addr == {3'h0, active_set} ##1
    $stable(active_set)[*2] |-> fb == {$past(reg_wr_data, 2), 1'b0}) else $error("write lost");
  drive_match_a: assert property (reg_rd_en && reg_addr == ADDR_DRIVE_BASE + {3'h0, active_set}
    ##1 $stable(active_set) |-> out_drive_on == {reg_rd_data[7:5], reg_rd_data[3:1]})
    else $error("drive enables differ from register");
  style_match_a: assert property (reg_rd_en && reg_addr == ADDR_STYLE_BASE + {3'h0, active_set}
    ##1 $stable(active_set) |-> out_style_pick == {reg_rd_data[7:5], reg_rd_data[3:1]})
    else $error("style picks differ from register");
endmodule
bind pll_config_field_decode pll_cfg_chk chk (.clock(clock), .resetn(resetn),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .clk_src_sel_pin(clk_src_sel_pin),
  .freq_set_pick_pin(freq_set_pick_pin), .active_set(active_set), .loop_ctrl(loop_ctrl),
  .out_drive_on(out_drive_on), .out_style_pick(out_style_pick));

// File: tb/pll_config_field_decode_tb.sv
// Self-checking bench for the loop configuration block.
// Assumes the host model on the register port and the bound checker.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module pll_config_field_decode_tb
  import pll_cfg_pkg::*;
;
  logic clock, resetn, src;
  logic [1:0] pick, n, active_set;
  wire reg_wr_en, reg_rd_en;
  wire [4:0] reg_addr;
  wire [7:0] reg_wr_data, reg_rd_data;
  loop_ctrl_t loop_ctrl;
  logic [5:0] out_drive_on, out_style_pick;
  cfg_set_t sh [4];
  cfg_set_t s;
  int n_fail = 0;
  int num_checks = 0;
  logic [6:0] od_c [6] = '{7'h00, 7'h01, 7'h03, 7'h05, 7'h06, 7'h7F};
  host_model host (.clock(clock), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data));
  pll_config_field_decode dut (.clock(clock), .resetn(resetn), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .clk_src_sel_pin(src), .freq_set_pick_pin(pick),
    .active_set(active_set), .loop_ctrl(loop_ctrl), .out_drive_on(out_drive_on),
    .out_style_pick(out_style_pick));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // ---------------------------------------------------------------
  // Expectations
  // ---------------------------------------------------------------
  function automatic logic [7:0] qb(input logic [5:0] q);
    qb = {q[5:3], 1'b0, q[2:0], 1'b0};
  endfunction
  function automatic logic [7:0] exp_byte(input logic [4:0] a);
    cfg_set_t t;
    t = sh[a[1:0]];
    case (a[4:2])
      3'h0: exp_byte = t.fb_div_code;
      3'h1: exp_byte = {1'b0, t.out_div_code};
      3'h2: exp_byte = {1'b0, t.loop_skip, t.prescale_sel, t.input_div_sel, t.pump_current_sel};
      3'h3: exp_byte = qb(t.out_style_pick);
      3'h4: exp_byte = qb(t.out_drive_on);
      default: exp_byte = 8'h00;
    endcase
  endfunction
  function automatic loop_ctrl_t exp_lc(input cfg_set_t t, input logic x);
    loop_ctrl_t e;
    logic [6:0] c;
    logic [8:0] m;
    c = t.out_div_code;
    m = {t.fb_div_code, 1'b0};
    e.input_div = !x ? 3'h1 : (t.input_div_sel == 2'h0) ? 3'h1 : (t.input_div_sel == 2'h1) ?
      3'h2 : (t.input_div_sel == 2'h2) ? 3'h4 : 3'h5;
    e.prescale = t.prescale_sel[1] ? PRE_TWO : (t.prescale_sel[0] ? PRE_HALF : PRE_ONE);
    e.fb_div = m;
    e.out_div = (c < 7'h02) ? 7'h02 : (c <= 7'h05) ? c : {c[6:1], 1'b0};
    e.pump_current_sel = t.pump_current_sel;
    e.loop_skip = t.loop_skip;
    e.fb_range_ok = t.fb_div_code >= 8'h08 && t.fb_div_code <= 8'h7D;
    case (t.pump_current_sel)
      2'h0: e.pump_range_ok = m >= 9'h010 && m <= 9'h030;
      2'h1: e.pump_range_ok = m >= 9'h030 && m <= 9'h064;
      2'h2: e.pump_range_ok = m >= 9'h064 && m <= 9'h0FA;
      default: e.pump_range_ok = m >= 9'h0C0 && m <= 9'h0FA;
    endcase
    e.freq_num = 11'(t.loop_skip ? 9'h001 : m) << (t.prescale_sel[1] ? 2 : !t.prescale_sel[0]);
    e.freq_den = 11'(2 * e.input_div * e.out_div);
    exp_lc = e;
  endfunction
  // ---------------------------------------------------------------
  // Sequences
  // ---------------------------------------------------------------
  task automatic close_out();
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clock);
    resetn <= 1'b0;
    pick <= 2'h0;
    src <= 1'b0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    for (int k = 0; k < 4; k++) sh[k] = CFG_RESET[k];
  endtask
  task automatic rd_all();
    logic [7:0] d;
    for (int a = 0; a < 32; a++) begin
      host.rd(5'(a), d);
      `CHK(d, exp_byte(5'(a)))
    end
  endtask
  task automatic set_chk(input logic [1:0] k, input logic x);
    @(posedge clock);
    pick <= k;
    src <= x;
    repeat (8) @(posedge clock);
    @(negedge clock);
    `CHK(active_set, k)
    `CHK(loop_ctrl, exp_lc(sh[k], x))
    `CHK(out_drive_on, sh[k].out_drive_on)
    `CHK(out_style_pick, sh[k].out_style_pick)
  endtask
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
  initial begin
    resetn = 1'b0;
    src = 1'b0;
    pick = 2'h0;
    void'($urandom(32'hCEED));
    do_reset();
    rd_all();
    for (int k = 0; k < 8; k++) set_chk(2'(k), 1'(k >> 2));
    for (int i = 0; i < 20; i++) begin
      n = 2'($urandom_range(3));
      s.fb_div_code = (i == 0) ? 8'h08 : (i == 1) ? 8'h7D : host.pick_fb();
      s.pump_current_sel = host.pick_pump(s.fb_div_code);
      s.out_div_code = (i < 6) ? od_c[i] : 7'($urandom);
      s.loop_skip = 1'($urandom);
      s.prescale_sel = (i < 4) ? 2'(i) : host.pick_pre();
      s.input_div_sel = 2'(i);
      s.out_drive_on = 6'($urandom);
      s.out_style_pick = 6'($urandom);
      sh[n] = s;
      for (int k = 0; k < 5; k++) host.wr({3'(k), n}, exp_byte({3'(k), n}));
      rd_all();
      set_chk(n, 1'($urandom));
    end
    host.wr(ADDR_STYLE_BASE + 5'(n), 8'hFF);
    sh[n].out_style_pick = 6'h3F;
    host.wr(5'h14, 8'hFF);
    host.wr(5'h1F, 8'hFF);
    rd_all();
    set_chk(n, 1'b1);
    @(posedge clock);
    pick <= ~n;
    @(posedge clock);
    pick <= n;
    repeat (6) begin
      @(negedge clock);
      `CHK(active_set, n)
    end
    do_reset();
    rd_all();
    set_chk(2'h3, 1'b1);
    close_out();
  end
endmodule
